/* File: fwg_pkg.sv */
// Purpose: constants and types shared by the flash write guard block
// Assumes: 32-bit apb, one clock
// Notes: register offsets are byte addresses
`default_nettype none
package fwg_pkg;
    localparam logic [15:0] OFF_PE_EN_A = 16'h3800;
    localparam logic [15:0] OFF_PE_EN_B = 16'h3804;
    localparam logic [15:0] OFF_MODE_0 = 16'h3810;
    localparam logic [15:0] OFF_MODE_1 = 16'h3814;
    localparam logic [15:0] OFF_STAT_0 = 16'h3820;
    localparam logic [15:0] OFF_STAT_1 = 16'h3824;
    localparam logic [15:0] OFF_CMD_0 = 16'h3830;
    localparam logic [15:0] OFF_CMD_1 = 16'h3834;
    localparam logic [15:0] OFF_IRQ_STAT = 16'h3840;
    localparam logic [15:0] OFF_IRQ_MASK = 16'h3844;
    localparam logic [15:0] MODE_READ = 16'h0000;
    localparam logic [15:0] MODE_CODE_PE = 16'h0001;
    localparam logic [15:0] MODE_DATA_PE = 16'h0080;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam int EN_BIT = 0;
    localparam int ST_READY_BIT = 0;
    localparam int ST_VIOL_BIT = 1;
    localparam int ST_LOCK_BIT = 2;
    localparam logic [3:0] BUSY_CYCLES = 4'h8;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_PROGRAM, CMD_MULTI_PROGRAM, CMD_DMA_PROGRAM, CMD_BLOCK_ERASE,
        CMD_AREA_ERASE, CMD_BLANK_CHECK, CMD_SUSPEND, CMD_RESUME, CMD_SET_CONFIG,
        CMD_SET_PROTECT, CMD_SET_SECURITY, CMD_STATUS_CLEAR, CMD_FORCED_STOP
    } cmd_e;
    typedef enum logic [1:0] {M_READ, M_CODE_PE, M_DATA_PE} mode_e;
    typedef struct packed {
        logic code_other_bank;
        logic code_ctrl_bank;
        logic extra_area;
        logic data_bank0;
        logic data_bank1;
    } read_allow_s;
endpackage : fwg_pkg
`default_nettype wire

/* File: flash_write_guard_and_mode_entry.sv */
// Purpose: program/erase enable guard and sequencer mode entry for two instances
// Assumes: apb3 slave, 25 MHz pclk, asynchronous active-low reset
// Notes: command execution is modelled as a fixed busy count
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module flash_write_guard_and_mode_entry (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [15:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped
    output logic irq, // level interrupt
    output fwg_pkg::read_allow_s read_allow // flash read permissions
);
    // ****************************************
    // bus decode
    // ****************************************
    // one wait state: pready answers a cycle into the access phase
    wire logic acc = psel && penable && !pready;
    // writes land on the completing edge, where the master samples pready
    wire logic wr = psel && penable && pready && pwrite;
    wire logic hit_en_a = (paddr == fwg_pkg::OFF_PE_EN_A);
    wire logic hit_en_b = (paddr == fwg_pkg::OFF_PE_EN_B);
    wire logic hit_mode0 = (paddr == fwg_pkg::OFF_MODE_0);
    wire logic hit_mode1 = (paddr == fwg_pkg::OFF_MODE_1);
    wire logic hit_stat0 = (paddr == fwg_pkg::OFF_STAT_0);
    wire logic hit_stat1 = (paddr == fwg_pkg::OFF_STAT_1);
    wire logic hit_cmd0 = (paddr == fwg_pkg::OFF_CMD_0);
    wire logic hit_cmd1 = (paddr == fwg_pkg::OFF_CMD_1);
    wire logic hit_ist = (paddr == fwg_pkg::OFF_IRQ_STAT);
    wire logic hit_imk = (paddr == fwg_pkg::OFF_IRQ_MASK);
    wire logic mapped = hit_en_a | hit_en_b | hit_mode0 | hit_mode1 | hit_stat0 | hit_stat1
        | hit_cmd0 | hit_cmd1 | hit_ist | hit_imk;

    function automatic logic is_guarded(input logic [3:0] c);
        is_guarded = (c >= 4'(fwg_pkg::CMD_PROGRAM)) && (c <= 4'(fwg_pkg::CMD_SET_SECURITY));
    endfunction : is_guarded

    function automatic logic [1:0] mode_next(input logic [15:0] v, input logic [1:0] cur,
        input logic code_ok);
        if (v == fwg_pkg::MODE_READ) begin
            mode_next = 2'(fwg_pkg::M_READ);
        end else if (v == fwg_pkg::MODE_CODE_PE && code_ok) begin
            mode_next = 2'(fwg_pkg::M_CODE_PE);
        end else if (v == fwg_pkg::MODE_DATA_PE) begin
            mode_next = 2'(fwg_pkg::M_DATA_PE);
        end else begin
            mode_next = cur;
        end
    endfunction : mode_next

    // ****************************************
    // enable registers
    // ****************************************
    logic en_a_q, en_b_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_a_q <= fwg_pkg::ENABLE_RESET[fwg_pkg::EN_BIT];
            en_b_q <= fwg_pkg::ENABLE_RESET[fwg_pkg::EN_BIT];
        end else begin
            if (wr && hit_en_a) en_a_q <= pwdata[fwg_pkg::EN_BIT];
            if (wr && hit_en_b) en_b_q <= pwdata[fwg_pkg::EN_BIT];
        end
    end
    wire logic pe_enabled = en_a_q && en_b_q;

    // ****************************************
    // per-instance mode, busy, flags
    // ****************************************
    logic [1:0] mode_q [2];
    logic [3:0] busy_q [2];
    logic viol_q [2];
    logic lock_q [2];
    wire logic [1:0] ev_viol, ev_done;
    wire logic [1:0] hit_mode = {hit_mode1, hit_mode0};
    wire logic [1:0] hit_cmd = {hit_cmd1, hit_cmd0};
    wire logic [3:0] cmd_w = pwdata[3:0];

    for (genvar i = 0; i < 2; i++) begin : g_inst
        wire logic cmd_wr = wr && hit_cmd[i];
        // read mode never accepts commands
        wire logic accept = cmd_wr && (mode_q[i] != 2'(fwg_pkg::M_READ));
        wire logic guarded = accept && is_guarded(cmd_w);
        wire logic start = guarded && pe_enabled && !lock_q[i] && (busy_q[i] == 4'h0);
        wire logic bad = guarded && !pe_enabled;
        wire logic clr = accept && (cmd_w == 4'(fwg_pkg::CMD_STATUS_CLEAR));
        wire logic stop = accept && (cmd_w == 4'(fwg_pkg::CMD_FORCED_STOP));
        assign ev_viol[i] = bad;
        assign ev_done[i] = (busy_q[i] == 4'h1);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_q[i] <= 2'(fwg_pkg::M_READ);
                busy_q[i] <= 4'h0;
                viol_q[i] <= 1'b0;
                lock_q[i] <= 1'b0;
            end else begin
                if (wr && hit_mode[i] && busy_q[i] == 4'h0) begin
                    // only the first instance owns code flash
                    mode_q[i] <= mode_next(pwdata[15:0], mode_q[i], i == 0);
                end
                if (stop) begin
                    busy_q[i] <= 4'h0;
                end else if (start) begin
                    busy_q[i] <= fwg_pkg::BUSY_CYCLES;
                end else if (busy_q[i] != 4'h0) begin
                    busy_q[i] <= busy_q[i] - 4'h1;
                end
                // violation wins over a clear in the same cycle
                if (bad) begin
                    viol_q[i] <= 1'b1;
                    lock_q[i] <= 1'b1;
                end else if (clr || stop) begin
                    viol_q[i] <= 1'b0;
                    lock_q[i] <= 1'b0;
                end
            end
        end
    end

    // a flagged violation blocks reads just as a running command does
    wire logic [1:0] hold;
    assign hold[0] = (busy_q[0] != 4'h0) || viol_q[0];
    assign hold[1] = (busy_q[1] != 4'h0) || viol_q[1];

    // ****************************************
    // read permissions
    // ****************************************
    wire logic code_blk = (mode_q[0] == 2'(fwg_pkg::M_CODE_PE)) && hold[0];
    wire logic d0_blk = (mode_q[0] == 2'(fwg_pkg::M_DATA_PE)) && hold[0];
    wire logic d1_blk = (mode_q[1] == 2'(fwg_pkg::M_DATA_PE)) && hold[1];
    fwg_pkg::read_allow_s allow_d;
    assign allow_d.code_other_bank = 1'b1;
    assign allow_d.code_ctrl_bank = !code_blk;
    assign allow_d.extra_area = !(code_blk || d0_blk || d1_blk);
    assign allow_d.data_bank0 = !d0_blk;
    assign allow_d.data_bank1 = !d1_blk;

    // ****************************************
    // interrupt status and mask
    // ****************************************
    logic [3:0] ist_q, imk_q;
    wire logic [3:0] ev = {ev_done, ev_viol};
    // an event in the clearing cycle survives: set wins over w1c
    wire logic [3:0] w1c = (wr && hit_ist) ? pwdata[3:0] : 4'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= 4'h0;
            imk_q <= 4'h0;
        end else begin
            ist_q <= (ist_q & ~w1c) | ev;
            if (wr && hit_imk) imk_q <= pwdata[3:0];
        end
    end

    // ****************************************
    // read mux and registered outputs
    // ****************************************
    function automatic logic [31:0] stat_word(input logic [3:0] b, input logic v, input logic l);
        stat_word = 32'h0;
        stat_word[fwg_pkg::ST_READY_BIT] = (b == 4'h0);
        stat_word[fwg_pkg::ST_VIOL_BIT] = v;
        stat_word[fwg_pkg::ST_LOCK_BIT] = l;
    endfunction : stat_word

    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0;
        if (hit_en_a) begin
            rd_d[fwg_pkg::EN_BIT] = en_a_q;
        end else if (hit_en_b) begin
            rd_d[fwg_pkg::EN_BIT] = en_b_q;
        end else if (hit_mode0) begin
            rd_d = (mode_q[0] == 2'(fwg_pkg::M_CODE_PE)) ? 32'(fwg_pkg::MODE_CODE_PE) :
                (mode_q[0] == 2'(fwg_pkg::M_DATA_PE)) ? 32'(fwg_pkg::MODE_DATA_PE) : 32'h0;
        end else if (hit_mode1) begin
            rd_d = (mode_q[1] == 2'(fwg_pkg::M_DATA_PE)) ? 32'(fwg_pkg::MODE_DATA_PE) : 32'h0;
        end else if (hit_stat0) begin
            rd_d = stat_word(busy_q[0], viol_q[0], lock_q[0]);
        end else if (hit_stat1) begin
            rd_d = stat_word(busy_q[1], viol_q[1], lock_q[1]);
        end else if (hit_ist) begin
            rd_d = {28'h0, ist_q};
        end else if (hit_imk) begin
            rd_d = {28'h0, imk_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
            // nothing can be running in reset, so every area stays readable
            read_allow <= '1;
        end else begin
            pready <= acc;
            pslverr <= acc && !mapped;
            prdata <= (acc && !pwrite) ? rd_d : 32'h0;
            irq <= |(ist_q & imk_q);
            read_allow <= allow_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_en_reset;
        @(posedge pclk) $rose(presetn) |-> !en_a_q && !en_b_q;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("enable not zero after reset");

    property p_no_start_disabled;
        @(posedge pclk) disable iff (!presetn)
        (busy_q[0] == 4'h0 && !pe_enabled) |=> busy_q[0] != fwg_pkg::BUSY_CYCLES;
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled) else $error("command ran while disabled");

    property p_viol_set;
        @(posedge pclk) disable iff (!presetn) ev_viol[0] |=> viol_q[0];
    endproperty
    a_viol_set: assert property (p_viol_set) else $error("violation flag not set");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (acc && !pwrite && (hit_en_a || hit_en_b)) |=> prdata[31:1] == 31'h0 && pready;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_mode_stable;
        @(posedge pclk) disable iff (!presetn) !(wr && hit_mode0) |=> $stable(mode_q[0]);
    endproperty
    a_mode_stable: assert property (p_mode_stable) else $error("mode changed without write");

    property p_code_entry;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_mode0 && busy_q[0] == 4'h0 && pwdata[15:0] == fwg_pkg::MODE_CODE_PE)
        |=> mode_q[0] == 2'(fwg_pkg::M_CODE_PE);
    endproperty
    a_code_entry: assert property (p_code_entry) else $error("code mode not entered");

    property p_code_block;
        @(posedge pclk) disable iff (!presetn)
        (mode_q[0] == 2'(fwg_pkg::M_CODE_PE) && hold[0]) |=> !read_allow.code_ctrl_bank
            && !read_allow.extra_area && read_allow.code_other_bank;
    endproperty
    a_code_block: assert property (p_code_block) else $error("code bank not blocked");

    property p_data_block;
        @(posedge pclk) disable iff (!presetn)
        (mode_q[1] == 2'(fwg_pkg::M_DATA_PE) && hold[1] && !hold[0]) |=> !read_allow.data_bank1
            && read_allow.data_bank0 && read_allow.code_ctrl_bank;
    endproperty
    a_data_block: assert property (p_data_block) else $error("data bank not blocked");

    // the code value counts as undefined for the second instance
    property p_bad_mode;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_mode1 && pwdata[15:0] != fwg_pkg::MODE_READ
            && pwdata[15:0] != fwg_pkg::MODE_DATA_PE) |=> $stable(mode_q[1]);
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("undefined mode accepted");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_cmd0 && mode_q[0] != 2'(fwg_pkg::M_READ) && !ev_viol[0]
            && pwdata[3:0] == 4'(fwg_pkg::CMD_STATUS_CLEAR)) |=> !viol_q[0] && !lock_q[0];
    endproperty
    a_clear: assert property (p_clear) else $error("status clear failed");

    property p_data_entry;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_mode1 && busy_q[1] == 4'h0 && pwdata[15:0] == fwg_pkg::MODE_DATA_PE)
        |=> mode_q[1] == 2'(fwg_pkg::M_DATA_PE);
    endproperty
    a_data_entry: assert property (p_data_entry) else $error("data mode not entered");

    // second instance takes the data code without disturbing the first
    property p_dual_data;
        @(posedge pclk) disable iff (!presetn)
        (mode_q[0] == 2'(fwg_pkg::M_DATA_PE) && wr && hit_mode1 && busy_q[1] == 4'h0
            && pwdata[15:0] == fwg_pkg::MODE_DATA_PE)
        |=> mode_q[0] == 2'(fwg_pkg::M_DATA_PE) && mode_q[1] == 2'(fwg_pkg::M_DATA_PE);
    endproperty
    a_dual_data: assert property (p_dual_data) else $error("dual data mode refused");

    property p_read_idle;
        @(posedge pclk) disable iff (!presetn)
        (mode_q[0] == 2'(fwg_pkg::M_READ) && busy_q[0] == 4'h0) |=> busy_q[0] == 4'h0;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read mode ran");

    property p_read_open;
        @(posedge pclk) disable iff (!presetn)
        (mode_q[0] == 2'(fwg_pkg::M_READ) && mode_q[1] == 2'(fwg_pkg::M_READ))
        |=> &read_allow;
    endproperty
    a_read_open: assert property (p_read_open) else $error("read mode blocked");

    property p_gate_second;
        @(posedge pclk) disable iff (!presetn)
        (busy_q[1] == 4'h0 && !pe_enabled) |=> busy_q[1] == 4'h0;
    endproperty
    a_gate_second: assert property (p_gate_second) else $error("ran while disabled");

    property p_viol_second;
        @(posedge pclk) disable iff (!presetn) ev_viol[1] |=> viol_q[1] && lock_q[1];
    endproperty
    a_viol_second: assert property (p_viol_second) else $error("second flag not set");

    property p_odd_mode0;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_mode0 && pwdata[15:0] != fwg_pkg::MODE_READ
            && pwdata[15:0] != fwg_pkg::MODE_CODE_PE && pwdata[15:0] != fwg_pkg::MODE_DATA_PE)
        |=> $stable(mode_q[0]);
    endproperty
    a_odd_mode0: assert property (p_odd_mode0) else $error("undefined mode taken");

    c_start: cover property (@(posedge pclk) disable iff (!presetn)
        busy_q[0] == 4'h0 ##1 busy_q[0] == fwg_pkg::BUSY_CYCLES);
    c_viol: cover property (@(posedge pclk) disable iff (!presetn) ev_viol[1]);
    c_dual: cover property (@(posedge pclk) disable iff (!presetn)
        mode_q[0] == 2'(fwg_pkg::M_DATA_PE) && mode_q[1] == 2'(fwg_pkg::M_DATA_PE));
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_stop: cover property (@(posedge pclk) disable iff (!presetn)
        busy_q[1] > 4'h1 ##1 busy_q[1] == 4'h0);
endmodule : flash_write_guard_and_mode_entry
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the flash write guard and mode entry block
// Assumes: apb master in the bench, 25 MHz pclk, reset held 20 cycles
// Notes: command busy time of 8 cycles is covered by fixed 12-cycle waits
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // signals and design instance
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    fwg_pkg::read_allow_s read_allow;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    always #20 pclk = ~pclk;

    flash_write_guard_and_mode_entry uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .read_allow(read_allow)
    );

    // ****************************************
    // reporting and bus tasks
    // ****************************************
    task conclude;
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // a hung bus must still reach the verdict
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("CHECK FAILED %0t bench timeout", $time);
            conclude();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // full-word transfer; request held until pready is sampled high or 20 cycles pass
    task xfer(input logic wr_en, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1, "no ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [15:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask : rdchk

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({27'h0, read_allow}, 32'h1f, "reset readable");
        rdchk(fwg_pkg::OFF_PE_EN_A, fwg_pkg::ENABLE_RESET, "enable a reset");
        rdchk(fwg_pkg::OFF_PE_EN_B, fwg_pkg::ENABLE_RESET, "enable b reset");
        wr(fwg_pkg::OFF_CMD_0, 32'h1);
        rdchk(fwg_pkg::OFF_STAT_0, 32'h1, "read mode refuses");
        wr(fwg_pkg::OFF_MODE_0, {16'h0, fwg_pkg::MODE_CODE_PE});
        rdchk(fwg_pkg::OFF_MODE_0, 32'h1, "code mode entry");
        wr(fwg_pkg::OFF_PE_EN_A, 32'h1);
        rdchk(fwg_pkg::OFF_PE_EN_A, 32'h1, "enable a bit");
        // only one enable set: every guarded code must trip the flag
        for (int c = 1; c <= 11; c++) begin
            wr(fwg_pkg::OFF_CMD_0, 32'(c));
            rdchk(fwg_pkg::OFF_STAT_0, 32'h7, "violation");
            wr(fwg_pkg::OFF_CMD_0, 32'hc);
            rdchk(fwg_pkg::OFF_STAT_0, 32'h1, "status clear");
        end
        wr(fwg_pkg::OFF_CMD_0, 32'h5);
        rdchk(fwg_pkg::OFF_IRQ_STAT, 32'h1, "violation event");
        chk({31'h0, irq}, 32'h0, "masked irq");
        chk({27'h0, read_allow}, 32'h13, "violation blocks");
        wr(fwg_pkg::OFF_IRQ_MASK, 32'h1);
        rdchk(fwg_pkg::OFF_IRQ_MASK, 32'h1, "mask");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(fwg_pkg::OFF_IRQ_STAT, 32'h1);
        rdchk(fwg_pkg::OFF_IRQ_STAT, 32'h0, "w1c");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(fwg_pkg::OFF_CMD_0, 32'hc);
        rdchk(fwg_pkg::OFF_STAT_0, 32'h1, "lock released");
        wr(fwg_pkg::OFF_PE_EN_B, 32'h1);
        rdchk(fwg_pkg::OFF_PE_EN_B, 32'h1, "enable b bit");
        wr(fwg_pkg::OFF_CMD_0, 32'h1);
        rdchk(fwg_pkg::OFF_STAT_0, 32'h0, "command runs");
        chk({27'h0, read_allow}, 32'h13, "busy blocks");
        wr(fwg_pkg::OFF_MODE_0, 32'h0);
        repeat (12) @(posedge pclk);
        rdchk(fwg_pkg::OFF_STAT_0, 32'h1, "command done");
        rdchk(fwg_pkg::OFF_MODE_0, 32'h1, "mode kept while busy");
        rdchk(fwg_pkg::OFF_IRQ_STAT, 32'h4, "done event");
        wr(fwg_pkg::OFF_IRQ_STAT, 32'h4);
        chk({27'h0, read_allow}, 32'h1f, "ready unblocks");
        wr(fwg_pkg::OFF_MODE_0, {16'h0, fwg_pkg::MODE_DATA_PE});
        wr(fwg_pkg::OFF_MODE_1, {16'h0, fwg_pkg::MODE_DATA_PE});
        wr(fwg_pkg::OFF_MODE_1, 32'h5);
        wr(fwg_pkg::OFF_MODE_1, 32'h1);
        wr(fwg_pkg::OFF_MODE_0, 32'h100);
        rdchk(fwg_pkg::OFF_MODE_0, 32'h80, "dual data mode");
        rdchk(fwg_pkg::OFF_MODE_1, 32'h80, "undefined kept");
        wr(fwg_pkg::OFF_CMD_1, 32'h4);
        rdchk(fwg_pkg::OFF_STAT_1, 32'h0, "data busy");
        chk({27'h0, read_allow}, 32'h1a, "data bank blocked");
        repeat (12) @(posedge pclk);
        chk({27'h0, read_allow}, 32'h1f, "data bank free");
        wr(fwg_pkg::OFF_CMD_1, 32'h1);
        wr(fwg_pkg::OFF_CMD_1, 32'hd);
        rdchk(fwg_pkg::OFF_STAT_1, 32'h1, "forced stop");
        chk({27'h0, read_allow}, 32'h1f, "stop unblocks");
        wr(fwg_pkg::OFF_PE_EN_A, 32'h0);
        wr(fwg_pkg::OFF_CMD_1, 32'h6);
        rdchk(fwg_pkg::OFF_STAT_1, 32'h7, "second violation");
        chk({27'h0, read_allow}, 32'h1a, "violation blocks data");
        rdchk(fwg_pkg::OFF_IRQ_STAT, 32'ha, "second events");
        wr(fwg_pkg::OFF_CMD_1, 32'hc);
        rdchk(fwg_pkg::OFF_STAT_1, 32'h1, "second clear");
        wr(fwg_pkg::OFF_MODE_0, 32'h0);
        rdchk(fwg_pkg::OFF_MODE_0, 32'h0, "back to read");
        xfer(1'b0, 16'h3900, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        conclude();
    end
endmodule : testbench
`default_nettype wire
